// ### rtl/fhrs_consts.svh
// Constants for the fault hiccup restart sequencer.
// Assumes inclusion by the package, the top module and the bench.
`ifndef FHRS_CONSTS_SVH
`define FHRS_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FHRS_ADDR_CTRL 8'h00
`define FHRS_ADDR_STATUS 8'h04
`define FHRS_ADDR_EVENTS 8'h08
`define FHRS_ADDR_MASK 8'h0C

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define FHRS_CTRL_LATCH_BIT 0
`define FHRS_CTRL_FORCE_OFF_BIT 1
`define FHRS_CTRL_RESET 2'h0
`define FHRS_MASK_RESET 5'h00
`define FHRS_EV_UNDERVOLT 0
`define FHRS_EV_OVERLOAD 1
`define FHRS_EV_THERMAL 2
`define FHRS_EV_RESTART 3
`define FHRS_EV_LINE 4
`define FHRS_EV_WIDTH 5

// ----------------------------------------
// Comparator flag positions
// ----------------------------------------
`define FHRS_CMP_BELOW_OFF 0
`define FHRS_CMP_ABOVE_ON 1
`define FHRS_CMP_BELOW_RESET 2
`define FHRS_CMP_OVERLOAD 3
`define FHRS_CMP_OVER_TEMP 4
`define FHRS_CMP_COOLED 5
`define FHRS_CMP_BROWN_OUT 6
`define FHRS_CMP_LINE_GONE 7
`define FHRS_CMP_WIDTH 8

// ----------------------------------------
// Counts and bus answers
// ----------------------------------------
`define FHRS_HICCUP_LIMIT 2'h3
`define FHRS_RESP_OKAY 2'h0
`define FHRS_RESP_SLVERR 2'h2

`endif

// ### rtl/fhrs_pkg.sv
// Types shared by the fault hiccup restart sequencer.
// Assumes the constants header sits beside it.
`include "fhrs_consts.svh"

package fhrs_pkg;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    FHRS_OFF,
    FHRS_RUN,
    FHRS_HICCUP,
    FHRS_THERMAL,
    FHRS_LATCHED
  } fhrs_state_e;

  // ----------------------------------------
  // Comparator flags, MSB first so bit index matches the header
  // ----------------------------------------
  typedef struct packed {
    logic line_gone;
    logic brown_out;
    logic temp_cooled;
    logic over_temp;
    logic overload;
    logic vcc_below_reset;
    logic vcc_above_on;
    logic vcc_below_off;
  } fhrs_cmp_s;

endpackage

// ### rtl/fhrs_top.sv
// Fault sequencer deciding when both drive stages run and when they restart.
// Assumes raw analog comparator flags, one clock CLK and an AXI4-Lite master.
//
// Functional notes
// - Supply below turn-off disables both drives and enters triple-hiccup recovery.
// - Overload on non-latching option also enters triple-hiccup recovery, not latch-off.
// - Hiccup is supply off then recharge to on; three needed before restart.
// - Over-temperature flag above the thermal limit disables the controller.
// - Thermal fault keeps the supply hiccuping without count limit while present.
// - After thermal fault, restart at next turn-on once cooled by the hysteresis.
// - Supply reset threshold, brown-out or line removal also clear thermal fault.
// - Fresh power-up starts at first turn-on crossing once all faults but overload are gone.
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`include "fhrs_consts.svh"

module fhrs_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Comparator flags from the analog front end
  input fhrs_pkg::fhrs_cmp_s CMP_FLAGS,
  // Drive enables and interrupt
  output logic PFC_DRIVE_EN,
  output logic FLY_DRIVE_EN,
  output logic IRQ,
  // AXI4-Lite write address
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read address
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import fhrs_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [`FHRS_CMP_WIDTH-1:0] raw;
  logic [`FHRS_CMP_WIDTH-1:0] sync1;
  logic [`FHRS_CMP_WIDTH-1:0] sync2;
  logic [`FHRS_CMP_WIDTH-1:0] sync3;
  logic [`FHRS_CMP_WIDTH-1:0] filt;
  logic on_prev;
  logic on_rise;
  fhrs_state_e state;
  fhrs_state_e next_state;
  logic [1:0] hiccup_cnt;
  logic [1:0] next_hiccup_cnt;
  logic saw_off;
  logic next_saw_off;
  logic thermal_fault;
  logic [`FHRS_EV_WIDTH-1:0] ev_set;
  logic [`FHRS_EV_WIDTH-1:0] events;
  logic [`FHRS_EV_WIDTH-1:0] next_events;
  logic [`FHRS_EV_WIDTH-1:0] mask;
  logic [1:0] ctrl;
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic rd_take;
  logic rd_clear;
  logic below_off;
  logic above_on;
  logic below_reset;
  logic overload;
  logic over_temp;
  logic cooled;
  logic line_fault;

  // Register address check, used by both the write and the read path
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `FHRS_ADDR_CTRL) || (a == `FHRS_ADDR_STATUS) ||
              (a == `FHRS_ADDR_EVENTS) || (a == `FHRS_ADDR_MASK);
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  assign raw = CMP_FLAGS;

  // Filtered value moves only when the second and third stages agree,
  // so a single metastable sample never reaches the sequencer
  genvar gi;
  generate
    for (gi = 0; gi < `FHRS_CMP_WIDTH; gi++)
    begin : g_sync
      always_ff @(posedge CLK)
      begin
        if (SRST)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          filt[gi] <= 1'b0;
        end
        else
        begin
          sync1[gi] <= raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi])
          begin
            filt[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  assign below_off = filt[`FHRS_CMP_BELOW_OFF];
  assign above_on = filt[`FHRS_CMP_ABOVE_ON];
  assign below_reset = filt[`FHRS_CMP_BELOW_RESET];
  assign overload = filt[`FHRS_CMP_OVERLOAD];
  assign over_temp = filt[`FHRS_CMP_OVER_TEMP];
  assign cooled = filt[`FHRS_CMP_COOLED];
  assign line_fault = filt[`FHRS_CMP_BROWN_OUT] | filt[`FHRS_CMP_LINE_GONE];

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      on_prev <= 1'b0;
    end
    else
    begin
      on_prev <= above_on;
    end
  end

  assign on_rise = above_on & ~on_prev;

  // ----------------------------------------
  // Thermal fault memory
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      thermal_fault <= 1'b0;
    end
    else if (over_temp)
    begin
      thermal_fault <= 1'b1;
    end
    else if (cooled || below_reset || line_fault)
    begin
      thermal_fault <= 1'b0;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Priority: temperature, supply reset, line, undervoltage, overload.
  always_comb
  begin
    next_state = state;
    next_hiccup_cnt = hiccup_cnt;
    next_saw_off = saw_off | below_off;
    ev_set = '0;
    if (over_temp && state != FHRS_THERMAL)
    begin
      next_state = FHRS_THERMAL;
      ev_set[`FHRS_EV_THERMAL] = 1'b1;
    end
    else if (below_reset)
    begin
      next_hiccup_cnt = 2'h0;
      next_saw_off = 1'b0;
      if (state != FHRS_OFF && state != FHRS_THERMAL)
      begin
        next_state = FHRS_OFF;
      end
    end
    else
    begin
      case (state)
        FHRS_OFF:
        begin
          if (on_rise && !line_fault && !thermal_fault && !ctrl[`FHRS_CTRL_FORCE_OFF_BIT])
          begin
            next_state = FHRS_RUN;
            ev_set[`FHRS_EV_RESTART] = 1'b1;
          end
        end
        FHRS_RUN:
        begin
          if (line_fault || ctrl[`FHRS_CTRL_FORCE_OFF_BIT])
          begin
            next_state = FHRS_OFF;
            ev_set[`FHRS_EV_LINE] = line_fault;
          end
          else if (below_off)
          begin
            next_state = FHRS_HICCUP;
            next_hiccup_cnt = 2'h0;
            next_saw_off = 1'b1;
            ev_set[`FHRS_EV_UNDERVOLT] = 1'b1;
          end
          else if (overload)
          begin
            ev_set[`FHRS_EV_OVERLOAD] = 1'b1;
            next_hiccup_cnt = 2'h0;
            next_saw_off = 1'b0;
            if (ctrl[`FHRS_CTRL_LATCH_BIT])
            begin
              next_state = FHRS_LATCHED;
            end
            else
            begin
              next_state = FHRS_HICCUP;
            end
          end
        end
        FHRS_HICCUP:
        begin
          if (line_fault)
          begin
            next_state = FHRS_OFF;
            ev_set[`FHRS_EV_LINE] = 1'b1;
          end
          else if (on_rise && saw_off)
          begin
            // Only a recharge that followed a drop to turn-off counts
            next_saw_off = 1'b0;
            if (hiccup_cnt == `FHRS_HICCUP_LIMIT - 2'h1)
            begin
              next_hiccup_cnt = 2'h0;
              if (ctrl[`FHRS_CTRL_FORCE_OFF_BIT])
              begin
                next_state = FHRS_OFF;
              end
              else
              begin
                next_state = FHRS_RUN;
                ev_set[`FHRS_EV_RESTART] = 1'b1;
              end
            end
            else
            begin
              next_hiccup_cnt = hiccup_cnt + 2'h1;
            end
          end
        end
        FHRS_THERMAL:
        begin
          // No count here: stays in supply hiccup until the fault clears
          next_hiccup_cnt = 2'h0;
          if (on_rise && !thermal_fault && !over_temp)
          begin
            if (line_fault || ctrl[`FHRS_CTRL_FORCE_OFF_BIT])
            begin
              next_state = FHRS_OFF;
            end
            else
            begin
              next_state = FHRS_RUN;
              ev_set[`FHRS_EV_RESTART] = 1'b1;
            end
          end
        end
        FHRS_LATCHED:
        begin
          // Latch holds until the supply falls through reset or over-temperature moves it to thermal
          next_state = FHRS_LATCHED;
        end
        default:
        begin
          next_state = FHRS_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      state <= FHRS_OFF;
      hiccup_cnt <= 2'h0;
      saw_off <= 1'b0;
    end
    else
    begin
      state <= next_state;
      hiccup_cnt <= next_hiccup_cnt;
      saw_off <= next_saw_off;
    end
  end

  // Both drives change on the same edge as the state, registered from next_state
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      PFC_DRIVE_EN <= 1'b0;
      FLY_DRIVE_EN <= 1'b0;
    end
    else
    begin
      PFC_DRIVE_EN <= (next_state == FHRS_RUN);
      FLY_DRIVE_EN <= (next_state == FHRS_RUN);
    end
  end

  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  // A new event in the clearing read's cycle survives: set wins
  always_comb
  begin
    next_events = (rd_clear ? '0 : events) | ev_set;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      events <= '0;
      IRQ <= 1'b0;
    end
    else
    begin
      events <= next_events;
      IRQ <= |(next_events & mask);
    end
  end

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  assign do_write = aw_got && w_got && !S_AXI_BVALID;

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `FHRS_RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_got <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_got <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write)
      begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= reg_hit(aw_addr) ? `FHRS_RESP_OKAY : `FHRS_RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // Only the low byte holds writable fields
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      ctrl <= `FHRS_CTRL_RESET;
      mask <= `FHRS_MASK_RESET;
    end
    else if (do_write && w_strb[0])
    begin
      if (aw_addr == `FHRS_ADDR_CTRL)
      begin
        ctrl <= w_data[1:0];
      end
      else if (aw_addr == `FHRS_ADDR_MASK)
      begin
        mask <= w_data[`FHRS_EV_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  assign rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_clear = rd_take && (S_AXI_ARADDR == `FHRS_ADDR_EVENTS);

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `FHRS_RESP_OKAY;
    end
    else if (rd_take)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= reg_hit(S_AXI_ARADDR) ? `FHRS_RESP_OKAY : `FHRS_RESP_SLVERR;
      if (S_AXI_ARADDR == `FHRS_ADDR_CTRL)
      begin
        S_AXI_RDATA <= {30'h0, ctrl};
      end
      else if (S_AXI_ARADDR == `FHRS_ADDR_STATUS)
      begin
        S_AXI_RDATA <= {23'h0, thermal_fault, 2'h0, hiccup_cnt, 1'b0, state};
      end
      else if (S_AXI_ARADDR == `FHRS_ADDR_EVENTS)
      begin
        S_AXI_RDATA <= {27'h0, events};
      end
      else if (S_AXI_ARADDR == `FHRS_ADDR_MASK)
      begin
        S_AXI_RDATA <= {27'h0, mask};
      end
      else
      begin
        S_AXI_RDATA <= 32'h0000_0000;
      end
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule

// ### tb/fhrs_monitor.sv
// Port-level checker for the fault hiccup restart sequencer.
// Assumes it is bound into fhrs_top and sees its ports only.
module fhrs_monitor
  import fhrs_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Flags and drive enables
  input fhrs_pkg::fhrs_cmp_s CMP_FLAGS,
  input wire logic PFC_DRIVE_EN,
  input wire logic FLY_DRIVE_EN,
  // Bus answers
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Flags pass three synchroniser flops and a filter flop, so 8 steady cycles leave margin for the decision
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  a_drives_paired: assert property (PFC_DRIVE_EN == FLY_DRIVE_EN)
    else $error("drive enables differ");
  a_undervolt_off: assert property (CMP_FLAGS.vcc_below_off [*8] |-> !PFC_DRIVE_EN)
    else $error("drive on with supply below turn-off");
  a_overload_off: assert property (CMP_FLAGS.overload [*8] |-> !PFC_DRIVE_EN)
    else $error("drive on during overload");
  a_thermal_off: assert property (CMP_FLAGS.over_temp [*8] |-> !PFC_DRIVE_EN)
    else $error("drive on while over temperature");
  a_restart_cooled: assert property ($rose(PFC_DRIVE_EN) |-> !$past(CMP_FLAGS.over_temp, 3))
    else $error("restart while still over temperature");
  a_restart_turn_on: assert property ($rose(PFC_DRIVE_EN) |-> $past(CMP_FLAGS.vcc_above_on, 3))
    else $error("restart without turn-on level");
  a_line_fault_off: assert property (CMP_FLAGS.line_gone [*8] |-> !PFC_DRIVE_EN)
    else $error("drive on with line removed");
  a_reset_level_off: assert property (CMP_FLAGS.vcc_below_reset [*8] |-> !PFC_DRIVE_EN)
    else $error("drive on below reset threshold");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered next cycle");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped before ready");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped before ready");

  c_drive_off: cover property ($fell(PFC_DRIVE_EN));
  c_drive_on: cover property ($rose(PFC_DRIVE_EN));
  c_write_done: cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule

bind fhrs_top fhrs_monitor u_mon (.CLK, .SRST, .CMP_FLAGS, .PFC_DRIVE_EN, .FLY_DRIVE_EN,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA,
  .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP);

// ### tb/fhrs_top_tb.sv
// Self-checking bench for the fault hiccup restart sequencer.
// Assumes fhrs_top with its AXI4-Lite slave and the bound port checker.
`include "fhrs_consts.svh"

module fhrs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fhrs_pkg::*;

  logic CLK, SRST, PFC_DRIVE_EN, FLY_DRIVE_EN, IRQ;
  fhrs_cmp_s CMP_FLAGS;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rr;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  int fails = 0;
  int tests_run = 0;

  fhrs_top u_dut (.CLK, .SRST, .CMP_FLAGS, .PFC_DRIVE_EN, .FLY_DRIVE_EN, .IRQ,
    .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY);

  initial
  begin
    CLK = 1'h0;
    forever #4 CLK = ~CLK;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("Counts: tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A wait that used up its bound counts as a mismatch and stops the run
  task automatic guard(input int n);
    if (n >= 40)
    begin
      chk(32'h1, 32'h0);
      end_sim();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
    end while (!(S_AXI_AWREADY && S_AXI_WREADY) && n < 40);
    do
    begin
      @(posedge CLK);
      n++;
    end while (!S_AXI_BVALID && n < 40);
    guard(n);
    S_AXI_BREADY <= 1'h1;
    @(posedge CLK);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'h0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end while (!S_AXI_ARREADY && n < 40);
    S_AXI_ARVALID <= 1'h0;
    do
    begin
      @(posedge CLK);
      n++;
    end while (!S_AXI_RVALID && n < 40);
    guard(n);
    S_AXI_RREADY <= 1'h1;
    @(posedge CLK);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'h0;
  endtask

  task automatic fld(input int idx, input logic v);
    @(posedge CLK);
    CMP_FLAGS[idx] <= v;
    repeat (10) @(posedge CLK);
  endtask

  // Supply either falls to turn-off or recharges to turn-on
  task automatic supply(input logic on);
    @(posedge CLK);
    CMP_FLAGS[`FHRS_CMP_BELOW_OFF] <= !on;
    CMP_FLAGS[`FHRS_CMP_ABOVE_ON] <= on;
    repeat (10) @(posedge CLK);
  endtask

  task automatic hiccup(input int n);
    repeat (n)
    begin
      supply(1'h0);
      supply(1'h1);
    end
  endtask

  task automatic drv(input logic exp);
    chk({30'h0, PFC_DRIVE_EN, FLY_DRIVE_EN}, {30'h0, exp, exp});
  endtask

  task automatic irq(input logic exp);
    repeat (2) @(posedge CLK);
    #1 chk({31'h0, IRQ}, {31'h0, exp});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_regs();
    axi_rd(`FHRS_ADDR_CTRL, rd, rr);
    chk(rd, 32'h0);
    axi_rd(`FHRS_ADDR_MASK, rd, rr);
    chk(rd, 32'h0);
    axi_rd(8'h10, rd, rr);
    chk({30'h0, rr}, {30'h0, `FHRS_RESP_SLVERR});
    axi_wr(8'h10, 32'h1, rr);
    chk({30'h0, rr}, {30'h0, `FHRS_RESP_SLVERR});
    axi_wr(`FHRS_ADDR_STATUS, 32'h7, rr);
    axi_rd(`FHRS_ADDR_STATUS, rd, rr);
    chk({29'h0, rd[2:0]}, 32'h0);
    axi_wr(`FHRS_ADDR_MASK, 32'h1F, rr);
    axi_rd(`FHRS_ADDR_MASK, rd, rr);
    chk(rd, 32'h1F);
    // Low byte strobe off: the write must leave the mask alone
    S_AXI_WSTRB <= 4'hE;
    axi_wr(`FHRS_ADDR_MASK, 32'h0, rr);
    S_AXI_WSTRB <= 4'hF;
    axi_rd(`FHRS_ADDR_MASK, rd, rr);
    chk(rd, 32'h1F);
    drv(1'h0);
    supply(1'h1);
    drv(1'h1);
  endtask

  task automatic s_undervolt();
    axi_rd(`FHRS_ADDR_EVENTS, rd, rr);
    irq(1'h0);
    supply(1'h0);
    drv(1'h0);
    irq(1'h1);
    axi_wr(`FHRS_ADDR_MASK, 32'h0, rr);
    irq(1'h0);
    axi_wr(`FHRS_ADDR_MASK, 32'h1F, rr);
    irq(1'h1);
    axi_rd(`FHRS_ADDR_EVENTS, rd, rr);
    chk({31'h0, rd[`FHRS_EV_UNDERVOLT]}, 32'h1);
    irq(1'h0);
    supply(1'h1);
    hiccup(1);
    drv(1'h0);
    axi_rd(`FHRS_ADDR_STATUS, rd, rr);
    chk({30'h0, rd[5:4]}, 32'h2);
    hiccup(1);
    drv(1'h1);
    axi_rd(`FHRS_ADDR_STATUS, rd, rr);
    chk({26'h0, rd[5:0]}, 32'h1);
  endtask

  task automatic s_overload();
    fld(`FHRS_CMP_OVERLOAD, 1'h1);
    drv(1'h0);
    fld(`FHRS_CMP_OVERLOAD, 1'h0);
    axi_rd(`FHRS_ADDR_EVENTS, rd, rr);
    chk({31'h0, rd[`FHRS_EV_OVERLOAD]}, 32'h1);
    hiccup(2);
    drv(1'h0);
    hiccup(1);
    drv(1'h1);
    // Latching option: hiccups alone never restart
    axi_wr(`FHRS_ADDR_CTRL, 32'h1, rr);
    fld(`FHRS_CMP_OVERLOAD, 1'h1);
    fld(`FHRS_CMP_OVERLOAD, 1'h0);
    hiccup(3);
    drv(1'h0);
    supply(1'h0);
    fld(`FHRS_CMP_BELOW_RESET, 1'h1);
    fld(`FHRS_CMP_BELOW_RESET, 1'h0);
    supply(1'h1);
    drv(1'h1);
    axi_wr(`FHRS_ADDR_CTRL, 32'h0, rr);
  endtask

  task automatic s_thermal();
    fld(`FHRS_CMP_OVER_TEMP, 1'h1);
    drv(1'h0);
    hiccup(4);
    drv(1'h0);
    axi_rd(`FHRS_ADDR_STATUS, rd, rr);
    chk({29'h0, rd[2:0]}, 32'h3);
    axi_rd(`FHRS_ADDR_EVENTS, rd, rr);
    chk({31'h0, rd[`FHRS_EV_THERMAL]}, 32'h1);
    fld(`FHRS_CMP_OVER_TEMP, 1'h0);
    fld(`FHRS_CMP_COOLED, 1'h1);
    drv(1'h0);
    hiccup(1);
    drv(1'h1);
    fld(`FHRS_CMP_COOLED, 1'h0);
  endtask

  task automatic s_thermal_clear();
    int src[3] = '{`FHRS_CMP_BELOW_RESET, `FHRS_CMP_BROWN_OUT, `FHRS_CMP_LINE_GONE};
    foreach (src[i])
    begin
      fld(`FHRS_CMP_OVER_TEMP, 1'h1);
      fld(`FHRS_CMP_OVER_TEMP, 1'h0);
      hiccup(1);
      drv(1'h0);
      supply(1'h0);
      fld(src[i], 1'h1);
      fld(src[i], 1'h0);
      supply(1'h1);
      drv(1'h1);
    end
  endtask

  // Force-off holds both drives off; a brown-out in run logs a line event
  task automatic s_force_off();
    axi_wr(`FHRS_ADDR_CTRL, 32'h2, rr);
    drv(1'h0);
    axi_wr(`FHRS_ADDR_CTRL, 32'h0, rr);
    hiccup(1);
    drv(1'h1);
    fld(`FHRS_CMP_BROWN_OUT, 1'h1);
    drv(1'h0);
    axi_rd(`FHRS_ADDR_EVENTS, rd, rr);
    chk({30'h0, rd[`FHRS_EV_LINE], rd[`FHRS_EV_RESTART]}, 32'h3);
    fld(`FHRS_CMP_BROWN_OUT, 1'h0);
    hiccup(1);
    drv(1'h1);
  endtask

  initial
  begin
    SRST = 1'h1;
    CMP_FLAGS = 8'h01;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
    S_AXI_AWADDR = 8'h00;
    S_AXI_ARADDR = 8'h00;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'hF;
    repeat (3) @(posedge CLK);
    SRST <= 1'h0;
    s_regs();
    s_undervolt();
    s_overload();
    s_thermal();
    s_thermal_clear();
    s_force_off();
    end_sim();
  end
endmodule
